// ==== hdl/audio_adc_power_control_regs.sv ====
// paged control registers for supply, fast charge, addressing and powerdown
`default_nettype none
module audio_adc_power_control_regs
    import pwr_ctrl_pkg::*;
#(
    parameter int unsigned REF_US   [4] = '{REF_T0_US, REF_T1_US, REF_T2_US, REF_T3_US},
    parameter int unsigned INCAP_US [4] = '{INCAP_T0_US, INCAP_T1_US, INCAP_T2_US, INCAP_T3_US},
    parameter int unsigned HOLD_US  [4] = '{HOLD_T0_US, HOLD_T1_US, HOLD_T2_US, HOLD_T3_US}
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [1:0] addr_sel_pins,
    output logic      [6:0] i2c_target_addr,
    input  wire logic       powerdown_pin_n,
    input  wire logic       clean_shutdown_done,
    output logic            core_regulator_en,
    output logic            analog_supply_source,
    output logic            awake,
    output logic            refcap_fastcharge_active,
    output logic            inputcap_fastcharge_active
);
    import pwr_ctrl_pkg::*;

    logic [7:0]      page_r;
    logic            restore_r;
    logic [7:0]      pmode_r;
    logic [7:0]      pdown_r;
    logic [7:0]      rdata_r;
    logic            awake_q_r;
    logic [TICK_W-1:0] tick_cnt_r;
    pd_state_type    pd_state_r;
    pd_state_type    pd_state_nxt;

    logic [NUM_TMR-1:0] tmr_start;
    logic [TMR_W-1:0]   tmr_load [NUM_TMR];
    logic [NUM_TMR-1:0] tmr_busy;
    logic [NUM_TMR-1:0] tmr_done;

    // page register answers on every page so software can always return
    wire on_page0   = (page_r == PAGE_ZERO);
    wire wr_page    = reg_wr_en && reg_addr == ADDR_PAGE;
    wire wr_restore = reg_wr_en && on_page0 && reg_addr == ADDR_RESTORE;
    wire wr_pmode   = reg_wr_en && on_page0 && reg_addr == ADDR_PMODE;
    wire wr_pdown   = reg_wr_en && on_page0 && reg_addr == ADDR_PDOWN;

    wire [1:0] ref_code   = pmode_r[REF_HI:REF_LO];
    wire [1:0] incap_code = pdown_r[INCAP_HI:INCAP_LO];
    wire [1:0] policy     = pdown_r[POL_HI:POL_LO];
    wire [1:0] hold_code  = pdown_r[HOLD_HI:HOLD_LO];
    wire       pd_asserted = !powerdown_pin_n;

    wire [7:0] restore_rd = {7'h00, restore_r};
    wire [7:0] rd_page0 =
        (reg_addr == ADDR_RESTORE) ? restore_rd :
        (reg_addr == ADDR_PMODE)   ? pmode_r :
        (reg_addr == ADDR_PDOWN)   ? pdown_r : READ_ZERO;
    wire [7:0] rd_value =
        (reg_addr == ADDR_PAGE) ? page_r :
        on_page0                ? rd_page0 : READ_ZERO;

    wire tick = (tick_cnt_r == TICK_W'(CYC_PER_TICK - 1));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + TICK_W'(1);
        end
    end

    // register file; a pending restore overrides any write in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            page_r    <= RST_PAGE;
            restore_r <= RST_RESTORE[RESTORE_BIT];
            pmode_r   <= RST_PMODE;
            pdown_r   <= RST_PDOWN;
        end else if (restore_r) begin
            page_r    <= RST_PAGE;
            restore_r <= RST_RESTORE[RESTORE_BIT];
            pmode_r   <= RST_PMODE;
            pdown_r   <= RST_PDOWN;
        end else begin
            if (wr_page) begin
                page_r <= reg_wdata;
            end
            if (wr_restore && reg_wdata[RESTORE_BIT]) begin
                restore_r <= 1'b1;
            end
            if (wr_pmode) begin
                pmode_r <= reg_wdata & WMASK_PMODE;
            end
            if (wr_pdown) begin
                pdown_r <= reg_wdata & WMASK_PDOWN;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= READ_ZERO;
        end else if (reg_rd_en) begin
            rdata_r <= rd_value;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            awake_q_r <= 1'b0;
        end else begin
            awake_q_r <= pmode_r[AWAKE_BIT];
        end
    end

    // fast charge runs once per wake-up; a short code shortens that wake only
    wire wake_rise = pmode_r[AWAKE_BIT] && !awake_q_r;

    assign tmr_start[TMR_REF]   = wake_rise;
    assign tmr_load[TMR_REF]    = TMR_W'(REF_US[ref_code]);
    assign tmr_start[TMR_INCAP] = wake_rise;
    assign tmr_load[TMR_INCAP]  = TMR_W'(INCAP_US[incap_code]);

    wire hold_start = (pd_state_r == PD_RUN) && pd_asserted && policy != POL_IMMEDIATE;
    assign tmr_start[TMR_HOLD] = hold_start;
    assign tmr_load[TMR_HOLD]  = TMR_W'(HOLD_US[hold_code]);

    genvar g;
    generate
        for (g = 0; g < NUM_TMR; g++) begin : g_tmr
            tick_timer_if tif ();
            assign tif.start   = tmr_start[g];
            assign tif.load    = tmr_load[g];
            assign tmr_busy[g] = tif.busy;
            assign tmr_done[g] = tif.done;
            tick_timer u_tmr (
                .core_clk (core_clk),
                .rst      (rst),
                .tick     (tick),
                .port     (tif.timer)
            );
        end
    endgenerate

    // policy 3 is treated like the timeout policy so the regulator cannot hang on
    wire hold_expired = tmr_done[TMR_HOLD] && policy != POL_CLEAN;

    always_comb begin
        pd_state_nxt = pd_state_r;
        case (pd_state_r)
            PD_RUN: begin
                if (pd_asserted) begin
                    if (policy == POL_IMMEDIATE) begin
                        pd_state_nxt = PD_OFF;
                    end else begin
                        pd_state_nxt = PD_HOLD;
                    end
                end
            end
            PD_HOLD: begin
                if (!pd_asserted) begin
                    pd_state_nxt = PD_RUN;
                end else if (clean_shutdown_done) begin
                    pd_state_nxt = PD_OFF;
                end else if (hold_expired) begin
                    pd_state_nxt = PD_OFF;
                end
            end
            PD_OFF: begin
                if (!pd_asserted) begin
                    pd_state_nxt = PD_RUN;
                end
            end
            default: begin
                pd_state_nxt = PD_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pd_state_r <= PD_RUN;
        end else begin
            pd_state_r <= pd_state_nxt;
        end
    end

    // cut in the same cycle the pin drops, without waiting for the state flop
    wire cut_now = (pd_state_r == PD_RUN) && pd_asserted && policy == POL_IMMEDIATE;
    assign core_regulator_en = (pd_state_r != PD_OFF) && !cut_now;

    assign i2c_target_addr = pmode_r[SHARED_BIT] ? SHARED_I2C_ADDR
                           : {ADDR_PREFIX, addr_sel_pins};
    assign analog_supply_source       = pmode_r[SRC_BIT];
    assign awake                      = pmode_r[AWAKE_BIT];
    assign refcap_fastcharge_active   = tmr_busy[TMR_REF];
    assign inputcap_fastcharge_active = tmr_busy[TMR_INCAP];
    assign reg_rdata                  = rdata_r;
endmodule
`default_nettype wire

// ==== hdl/pwr_ctrl_pkg.sv ====
// constants, field layout and types shared by the power control register bank
`default_nettype none
package pwr_ctrl_pkg;
    localparam logic [7:0] ADDR_PAGE    = 8'h00;
    localparam logic [7:0] ADDR_RESTORE = 8'h01;
    localparam logic [7:0] ADDR_PMODE   = 8'h02;
    localparam logic [7:0] ADDR_PDOWN   = 8'h05;
    localparam logic [7:0] PAGE_ZERO    = 8'h00;

    localparam logic [7:0] RST_PAGE    = 8'h00;
    localparam logic [7:0] RST_RESTORE = 8'h00;
    localparam logic [7:0] RST_PMODE   = 8'h00;
    localparam logic [7:0] RST_PDOWN   = 8'h05;

    localparam logic [7:0] WMASK_PMODE = 8'hFD;
    localparam logic [7:0] WMASK_PDOWN = 8'h3F;
    localparam logic [7:0] READ_ZERO   = 8'h00;

    localparam int RESTORE_BIT = 0;
    localparam int SRC_BIT     = 7;
    localparam int REF_HI      = 4;
    localparam int REF_LO      = 3;
    localparam int SHARED_BIT  = 2;
    localparam int AWAKE_BIT   = 0;
    localparam int INCAP_HI    = 5;
    localparam int INCAP_LO    = 4;
    localparam int POL_HI      = 3;
    localparam int POL_LO      = 2;
    localparam int HOLD_HI     = 1;
    localparam int HOLD_LO     = 0;

    localparam logic [1:0] POL_IMMEDIATE = 2'h0;
    localparam logic [1:0] POL_TIMEOUT   = 2'h1;
    localparam logic [1:0] POL_CLEAN     = 2'h2;

    localparam logic [6:0] SHARED_I2C_ADDR = 7'h4C;
    localparam logic [4:0] ADDR_PREFIX     = 5'h13;

    localparam int unsigned CLK_FREQ_KHZ = 40000;
    localparam int unsigned TICK_US      = 1;
    localparam int unsigned CYC_PER_TICK = CLK_FREQ_KHZ * TICK_US / 1000;
    localparam int          TICK_W       = 6;
    localparam int          TMR_W        = 17;
    localparam int          NUM_TMR      = 3;
    localparam int          TMR_REF      = 0;
    localparam int          TMR_INCAP    = 1;
    localparam int          TMR_HOLD     = 2;

    localparam int unsigned REF_T0_US   = 3500;
    localparam int unsigned REF_T1_US   = 10000;
    localparam int unsigned REF_T2_US   = 50000;
    localparam int unsigned REF_T3_US   = 100000;
    localparam int unsigned INCAP_T0_US = 2500;
    localparam int unsigned INCAP_T1_US = 12500;
    localparam int unsigned INCAP_T2_US = 25000;
    localparam int unsigned INCAP_T3_US = 50000;
    localparam int unsigned HOLD_T0_US  = 30000;
    localparam int unsigned HOLD_T1_US  = 25000;
    localparam int unsigned HOLD_T2_US  = 10000;
    localparam int unsigned HOLD_T3_US  = 5000;

    typedef enum logic [1:0] {PD_RUN, PD_HOLD, PD_OFF} pd_state_type;
endpackage
`default_nettype wire

// ==== hdl/tick_timer_if.sv ====
// start, load and status signals between the bank and one duration timer
`default_nettype none
interface tick_timer_if;
    logic                           start;
    logic [pwr_ctrl_pkg::TMR_W-1:0] load;
    logic                           busy;
    logic                           done;
    modport ctrl  (output start, output load, input busy, input done);
    modport timer (input start, input load, output busy, output done);
endinterface
`default_nettype wire

// ==== hdl/tick_timer.sv ====
// down counter of microsecond ticks with busy level and done pulse
`default_nettype none
module tick_timer
    import pwr_ctrl_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic tick,
    tick_timer_if.timer port
);
    import pwr_ctrl_pkg::*;

    logic [TMR_W-1:0] cnt_r;
    logic             done_r;
    wire              last_tick = tick && (cnt_r == TMR_W'(1));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= last_tick && !port.start;
            // restart wins over expiry
            if (port.start) begin
                cnt_r <= port.load;
            end else if (tick && cnt_r != '0) begin
                cnt_r <= cnt_r - TMR_W'(1);
            end
        end
    end

    assign port.busy = (cnt_r != '0);
    assign port.done = done_r;
endmodule
`default_nettype wire

// ==== testbench/pwr_regs_chk.sv ====
// port-level assertions for the power control register bank
`default_nettype none
module pwr_regs_chk
    import pwr_ctrl_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] addr_sel_pins,
    input wire logic [6:0] i2c_target_addr,
    input wire logic       powerdown_pin_n,
    input wire logic       core_regulator_en,
    input wire logic       analog_supply_source,
    input wire logic       awake,
    input wire logic       refcap_fastcharge_active,
    input wire logic       inputcap_fastcharge_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] page_r;
    logic [7:0] wd_r;
    logic       restore_r;
    wire        pg0 = (page_r == PAGE_ZERO);
    wire        mapped = pg0 && (reg_addr inside {ADDR_RESTORE, ADDR_PMODE, ADDR_PDOWN});
    wire        rs_wr = reg_wr_en && pg0 && reg_addr == ADDR_RESTORE && reg_wdata[0];
    // shadow of the page; writes in the restore cycle are lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            page_r <= RST_PAGE;
            restore_r <= 1'b0;
        end else begin
            restore_r <= rs_wr && !restore_r;
            if (restore_r)
                page_r <= RST_PAGE;
            else if (reg_wr_en && reg_addr == ADDR_PAGE)
                page_r <= reg_wdata;
        end
    end
    always_ff @(posedge core_clk) wd_r <= reg_wdata;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_values: assert property ($fell(rst) |-> !awake && !analog_supply_source
        && reg_rdata == 8'h00) else $error("bad values after reset");
    a_pmode_write: assert property (reg_wr_en && pg0 && !restore_r && reg_addr == ADDR_PMODE
        |=> awake == wd_r[AWAKE_BIT] && analog_supply_source == wd_r[SRC_BIT])
        else $error("power mode write not applied");
    a_page_read: assert property (reg_rd_en && reg_addr == ADDR_PAGE
        |=> reg_rdata == $past(page_r)) else $error("page read wrong");
    a_rdata_hold: assert property (!reg_rd_en && !restore_r |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (reg_rd_en && reg_addr != ADDR_PAGE && !mapped
        |=> reg_rdata == READ_ZERO) else $error("unmapped read not zero");
    a_resv_pmode: assert property (reg_rd_en && pg0 && reg_addr == ADDR_PMODE
        |=> !reg_rdata[1]) else $error("power mode reserved bit set");
    a_resv_pdown: assert property (reg_rd_en && pg0 && reg_addr == ADDR_PDOWN
        |=> reg_rdata[7:6] == 2'h0) else $error("powerdown reserved bits set");
    a_resv_restore: assert property (reg_rd_en && pg0 && reg_addr == ADDR_RESTORE
        |=> reg_rdata[7:1] == 7'h00) else $error("restore reserved bits set");
    a_addr_choice: assert property (i2c_target_addr == 7'h4C
        || i2c_target_addr == {ADDR_PREFIX, addr_sel_pins}) else $error("bad target address");
    a_pin_high_on: assert property (powerdown_pin_n && $past(powerdown_pin_n)
        |-> core_regulator_en) else $error("regulator off with pin high");
    a_charge_start: assert property ($rose(awake) |-> ##[1:3]
        (refcap_fastcharge_active && inputcap_fastcharge_active)) else $error("no fast charge");
endmodule
`default_nettype wire

// ==== testbench/tb_audio_adc_power_control_regs.sv ====
// self-checking bench for the power control register bank
`default_nettype none
module tb_audio_adc_power_control_regs;
    import pwr_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned RU [4] = '{3, 10, 50, 100};
    localparam int unsigned IU [4] = '{2, 12, 25, 50};
    localparam int unsigned HU [4] = '{30, 25, 10, 5};
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       reg_wr_en = 1'b0;
    logic       reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] addr_sel_pins = 2'h0;
    logic       powerdown_pin_n = 1'b1;
    logic       clean_shutdown_done = 1'b0;
    logic [7:0] reg_rdata;
    logic [6:0] i2c_target_addr;
    logic       core_regulator_en, analog_supply_source, awake;
    logic       refcap_fastcharge_active, inputcap_fastcharge_active;
    logic [7:0] exp_q [$];
    logic [7:0] rnd = 8'h30;
    logic       rd_d = 1'b0;
    int         miscompares = 0;
    int         n_tests = 0;
    int         n, cr, ci, pol, hc;
    initial forever #12.5 core_clk = ~core_clk;
    audio_adc_power_control_regs #(.REF_US(RU), .INCAP_US(IU), .HOLD_US(HU)) i_dut (
        .core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .addr_sel_pins(addr_sel_pins), .i2c_target_addr(i2c_target_addr),
        .powerdown_pin_n(powerdown_pin_n), .clean_shutdown_done(clean_shutdown_done),
        .core_regulator_en(core_regulator_en), .analog_supply_source(analog_supply_source),
        .awake(awake), .refcap_fastcharge_active(refcap_fastcharge_active),
        .inputcap_fastcharge_active(inputcap_fastcharge_active));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic complete_run;
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask
    // the note travels with the strobe, the monitor pops it a cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        @(negedge core_clk);
        reg_rd_en = 1'b0;
    endtask
    always @(posedge core_clk) rd_d <= reg_rd_en;
    always @(negedge core_clk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0)
            cmp_val(reg_rdata, exp_q.pop_front());
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        rd(ADDR_PAGE, 8'h00);
        rd(ADDR_RESTORE, 8'h00);
        rd(ADDR_PMODE, 8'h00);
        rd(ADDR_PDOWN, 8'h05);
        rd(8'h03, 8'h00);
        rnd = lfsr(rnd) | 8'h01;
        wr(ADDR_PAGE, rnd);
        rd(ADDR_PAGE, rnd);
        wr(ADDR_PMODE, 8'hFF);
        rd(ADDR_PDOWN, 8'h00);
        wr(ADDR_PAGE, 8'h00);
        rd(ADDR_PMODE, 8'h00);
        wr(ADDR_PMODE, 8'hFF);
        rd(ADDR_PMODE, 8'hFD);
        cmp_val({7'h0, analog_supply_source}, 8'h01);
        cmp_val({1'b0, i2c_target_addr}, 8'h4C);
        wr(ADDR_PDOWN, 8'hFF);
        rd(ADDR_PDOWN, 8'h3F);
        wr(ADDR_RESTORE, 8'hFE);
        rd(ADDR_PMODE, 8'hFD);
        wr(ADDR_RESTORE, 8'h01);
        rd(ADDR_PMODE, 8'h00);
        rd(ADDR_PDOWN, 8'h05);
        rd(ADDR_RESTORE, 8'h00);
        cmp_val({7'h0, awake}, 8'h00);
        repeat (4) begin
            rnd = lfsr(rnd);
            @(negedge core_clk);
            addr_sel_pins = rnd[1:0];
            #1;
            cmp_val({1'b0, i2c_target_addr}, {1'b0, ADDR_PREFIX, rnd[1:0]});
        end
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_PDOWN, {2'h0, c[1:0], 4'h5});
            wr(ADDR_PMODE, {3'h0, c[1:0], 3'h0});
            wr(ADDR_PMODE, {3'h0, c[1:0], 3'h1});
            cmp_val({7'h0, awake}, 8'h01);
            cr = 0;
            ci = 0;
            repeat (4100) begin
                @(negedge core_clk);
                cr += int'(refcap_fastcharge_active === 1'b1);
                ci += int'(inputcap_fastcharge_active === 1'b1);
            end
            cmp_rng(cr, RU[c] * 40 - 40, RU[c] * 40 + 40);
            cmp_rng(ci, IU[c] * 40 - 40, IU[c] * 40 + 40);
        end
        // policy 0, policy 1 with every hold code, then policy 2 done at cycle 300
        for (int k = 0; k < 6; k++) begin
            pol = (k == 0) ? 0 : (k == 5) ? 2 : 1;
            hc = (k >= 1 && k <= 4) ? k - 1 : 3;
            wr(ADDR_PDOWN, {4'h0, pol[1:0], hc[1:0]});
            @(negedge core_clk);
            powerdown_pin_n = 1'b0;
            #1;
            n = 0;
            while (core_regulator_en !== 1'b0 && n < 1400) begin
                @(negedge core_clk);
                n++;
                clean_shutdown_done = (pol == 2 && n == 300);
            end
            case (pol)
                0: cmp_rng(n, 0, 0);
                1: cmp_rng(n, HU[hc] * 40 - 40, HU[hc] * 40 + 5);
                default: cmp_rng(n, 300, 302);
            endcase
            @(negedge core_clk);
            clean_shutdown_done = 1'b0;
            powerdown_pin_n = 1'b1;
            repeat (2) @(negedge core_clk);
            cmp_val({7'h0, core_regulator_en}, 8'h01);
        end
        complete_run();
    end
endmodule
bind audio_adc_power_control_regs pwr_regs_chk i_chk (
    .core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .addr_sel_pins(addr_sel_pins), .i2c_target_addr(i2c_target_addr),
    .powerdown_pin_n(powerdown_pin_n), .core_regulator_en(core_regulator_en),
    .analog_supply_source(analog_supply_source), .awake(awake),
    .refcap_fastcharge_active(refcap_fastcharge_active),
    .inputcap_fastcharge_active(inputcap_fastcharge_active));
`default_nettype wire
